// File: smt_pkg.sv
// Shared constants, types and timing counts for the siren mode control
`default_nettype none
package smt_pkg;
    // ------------------------------------------------------------------
    // Selector positions (one bit per position, all low between stops)
    // ------------------------------------------------------------------
    localparam int unsigned SEL_W        = 5;
    localparam int unsigned SEL_RADIO    = 0;
    localparam int unsigned SEL_MANUAL   = 1;
    localparam int unsigned SEL_WAIL     = 2;
    localparam int unsigned SEL_YELP     = 3;
    localparam int unsigned SEL_TWO_TONE = 4;
    localparam logic [SEL_W-1:0] SEL_NONE = 5'h00;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned SYS_CLK_KHZ    = 125000;
    localparam int unsigned HOLDOFF_MS     = 1000;
    localparam int unsigned HOLDOFF_CYC    = HOLDOFF_MS * SYS_CLK_KHZ;
    localparam int unsigned DEBOUNCE_US    = 1000;
    localparam int unsigned DEBOUNCE_CYC   =
        (DEBOUNCE_US * SYS_CLK_KHZ + 999) / 1000;
    localparam int unsigned CNT_W          = 28;

    // ------------------------------------------------------------------
    // Decoded siren mode, Gray coded along the selector order
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        SMT_MODE_NONE     = 3'h0,
        SMT_MODE_RADIO    = 3'h1,
        SMT_MODE_MANUAL   = 3'h3,
        SMT_MODE_WAIL     = 3'h2,
        SMT_MODE_YELP     = 3'h6,
        SMT_MODE_TWO_TONE = 3'h7,
        SMT_MODE_PA       = 3'h5
    } smt_mode_e;

    // Horn-ring acceptance state after power-up
    typedef enum logic {
        SMT_RING_HOLD  = 1'h0,
        SMT_RING_ARMED = 1'h1
    } smt_ring_e;

    // Front-panel and vehicle inputs
    typedef struct packed {
        logic [SEL_W-1:0] selector;    // Mode selector switch, one-hot
        logic             paddle_up;   // Paddle up: air horn
        logic             paddle_down; // Paddle down: peak and hold
        logic             ptt;         // Microphone push-to-talk
        logic             ring_pos;    // Horn ring contact, high side
        logic             ring_neg;    // Horn ring contact, low side
        logic             jumper_a;    // Horn ring sound jumper a, air only when a and b are both 1
        logic             jumper_b;    // Horn ring sound jumper b, air only when a and b are both 1
        logic             low_freq;    // Control level below low reference
        logic             rate_sq;     // Siren rate oscillator output
        logic             power_good;  // Siren circuitry powered
    } smt_panel_s;

    // Controls to the analog sections
    typedef struct packed {
        logic tone_inhibit;      // Tone oscillator inhibit
        logic airhorn_run;       // Air-horn rate oscillator released
        logic rate_discharge_en; // Siren rate discharge path enabled
        logic tone_src_airhorn;  // Tone control from air-horn level
        logic rate_square;       // Square two-level rate control
        logic yelp_ctrl;         // Yelp line to rate oscillator
        logic audio_radio;       // Amplifier fed from radio audio
        logic bias_en;           // Output stage biasing on
        logic horn_pulse;        // Horn ring pulse, qualified
    } smt_ctl_s;

    localparam smt_ctl_s CTL_RESET = '{
        tone_inhibit: 1'b1, rate_discharge_en: 1'b1, default: 1'b0};
endpackage : smt_pkg
`default_nettype wire

// File: smt_siren_mode_tone_control.sv
// Siren mode decode, horn ring toggle and tone control logic
// Operation
// - Inhibit tone oscillator while control level is below low reference.
// - Also inhibit tone oscillator for radio or push-to-talk.
// - Air-horn oscillator held in reset unless air-horn control high.
// - Peak request disables siren rate discharge path.
// - Tone control from air-horn level while air-horn override active.
// - Ramp rate control in manual, wail, yelp; square in two-tone.
// - Horn ring contact of either polarity gives matching high pulse.
// - In wail or yelp, debounced ring pulse toggles one flip-flop.
// - Toggle output XORed with yelp line swaps yelp and wail.
// - Selector no-position state clears the toggle flip-flop.
// - Manual with peak jumper: peak while horn ring pulse active.
// - Manual or two-tone with air jumper: air horn while pulse active.
// - Horn ring accepted only while siren circuitry powered.
// - Microphone audio by default, radio audio in radio position.
// - Output biasing on for radio or push-to-talk.
// - Mode decoded from selector and push-to-talk.
// - Push-to-talk overrides all siren functions except radio.
// - Horn ring held off about one second after power-up.
// - In manual, wail, yelp or two-tone, paddle up gives air horn, down gives peak.
`default_nettype none
module smt_siren_mode_tone_control
    import smt_pkg::*;
#(
    parameter int unsigned HOLDOFF_CYCLES  = HOLDOFF_CYC,
    parameter int unsigned DEBOUNCE_CYCLES = DEBOUNCE_CYC
) (
    input  wire logic       sys_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       ce_i,
    input  wire smt_panel_s panel_i,
    output var  smt_ctl_s   ctl_o,
    output var  smt_mode_e  mode_o,
    output var  logic       toggle_o
);

    // ------------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------------
    if (HOLDOFF_CYCLES < 1 || HOLDOFF_CYCLES >= (1 << CNT_W)) begin : g_ho
        $error("HOLDOFF_CYCLES out of counter range");
    end
    if (DEBOUNCE_CYCLES < 1 || DEBOUNCE_CYCLES >= (1 << CNT_W)) begin : g_db
        $error("DEBOUNCE_CYCLES out of counter range");
    end

    localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLDOFF_CYCLES - 1);
    localparam logic [CNT_W-1:0] DB_LAST   = CNT_W'(DEBOUNCE_CYCLES - 1);

    // ------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------
    // Radio wins over push-to-talk; push-to-talk wins over siren modes
    function automatic smt_mode_e decode_mode(
        input logic [SEL_W-1:0] sel,
        input logic             ptt
    );
        smt_mode_e m;
        m = SMT_MODE_NONE;
        if (sel == (SEL_W'(1) << SEL_RADIO)) begin
            m = SMT_MODE_RADIO;
        end else if (ptt) begin
            m = SMT_MODE_PA;
        end else if (sel == (SEL_W'(1) << SEL_MANUAL)) begin
            m = SMT_MODE_MANUAL;
        end else if (sel == (SEL_W'(1) << SEL_WAIL)) begin
            m = SMT_MODE_WAIL;
        end else if (sel == (SEL_W'(1) << SEL_YELP)) begin
            m = SMT_MODE_YELP;
        end else if (sel == (SEL_W'(1) << SEL_TWO_TONE)) begin
            m = SMT_MODE_TWO_TONE;
        end
        return m;
    endfunction

    // ------------------------------------------------------------------
    // Input synchroniser
    // ------------------------------------------------------------------
    smt_panel_s pin_meta;
    smt_panel_s pin;

    // Two flops on every pin; only the second is read
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_meta <= '0;
            pin      <= '0;
        end else if (ce_i) begin
            pin_meta <= panel_i;
            pin      <= pin_meta;
        end
    end

    // ------------------------------------------------------------------
    // Horn ring power-up hold-off and pulse qualification
    // ------------------------------------------------------------------
    smt_ring_e        ring_st;
    smt_ring_e        next_ring_st;
    logic [CNT_W-1:0] hold_cnt;
    logic [CNT_W-1:0] next_hold_cnt;
    logic             ring_pulse;

    // Count from release of reset and power good before arming the ring
    always_comb begin
        next_ring_st  = ring_st;
        next_hold_cnt = hold_cnt;
        unique case (ring_st)
            SMT_RING_HOLD: begin
                if (!pin.power_good) begin
                    next_hold_cnt = '0;
                end else if (hold_cnt == HOLD_LAST) begin
                    next_ring_st  = SMT_RING_ARMED;
                end else begin
                    next_hold_cnt = hold_cnt + CNT_W'(1);
                end
            end
            SMT_RING_ARMED: begin
                if (!pin.power_good) begin
                    next_ring_st  = SMT_RING_HOLD;
                    next_hold_cnt = '0;
                end
            end
        endcase
    end

    // Either contact polarity gives a high pulse of equal length
    assign ring_pulse = (pin.ring_pos | pin.ring_neg)
                        & (ring_st == SMT_RING_ARMED)
                        & pin.power_good;

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ring_st  <= SMT_RING_HOLD;
            hold_cnt <= '0;
        end else if (ce_i) begin
            ring_st  <= next_ring_st;
            hold_cnt <= next_hold_cnt;
        end
    end

    // ------------------------------------------------------------------
    // Debounce and toggle flip-flop
    // ------------------------------------------------------------------
    smt_mode_e        mode;
    logic [CNT_W-1:0] db_cnt;
    logic [CNT_W-1:0] next_db_cnt;
    logic             db_level;
    logic             next_db_level;
    logic             toggle;
    logic             next_toggle;
    logic [SEL_W-1:0] sel_prev;
    logic             tap_mode;

    assign mode     = decode_mode(pin.selector, pin.ptt);
    assign tap_mode = (mode == SMT_MODE_WAIL) || (mode == SMT_MODE_YELP);

    // Level must hold for the debounce count before it is taken
    always_comb begin
        next_db_cnt   = '0;
        next_db_level = db_level;
        next_toggle   = toggle;
        if (ring_pulse != db_level) begin
            if (db_cnt == DB_LAST) begin
                next_db_level = ring_pulse;
            end else begin
                next_db_cnt = db_cnt + CNT_W'(1);
            end
        end
        if (tap_mode && ring_pulse && !db_level
            && next_db_level) begin
            next_toggle = ~toggle;
        end
        // Selector between stops, or a new stop, restores true yelp line
        if (pin.selector == SEL_NONE || pin.selector != sel_prev) begin
            next_toggle = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            db_cnt   <= '0;
            db_level <= 1'b0;
            toggle   <= 1'b0;
            sel_prev <= SEL_NONE;
        end else if (ce_i) begin
            db_cnt   <= next_db_cnt;
            db_level <= next_db_level;
            toggle   <= next_toggle;
            sel_prev <= pin.selector;
        end
    end

    // ------------------------------------------------------------------
    // Control outputs
    // ------------------------------------------------------------------
    smt_ctl_s  next_ctl;
    logic      siren_on;
    logic      jumper_air;
    logic      peak_req;
    logic      air_req;
    logic      radio_or_ptt;

    assign siren_on     = (mode == SMT_MODE_MANUAL) || tap_mode
                          || (mode == SMT_MODE_TWO_TONE);
    assign jumper_air   = pin.jumper_a & pin.jumper_b;
    assign radio_or_ptt = (mode == SMT_MODE_RADIO) || pin.ptt;

    // Peak: paddle down, or ring in manual with peak jumper
    assign peak_req = siren_on & (pin.paddle_down
                      | ((mode == SMT_MODE_MANUAL) & ~jumper_air
                         & ring_pulse));

    // Air horn: paddle up, or ring in manual or two-tone with air jumper
    assign air_req = siren_on & (pin.paddle_up
                     | (((mode == SMT_MODE_MANUAL)
                         | (mode == SMT_MODE_TWO_TONE))
                        & jumper_air & ring_pulse));

    always_comb begin
        next_ctl                   = CTL_RESET;
        next_ctl.tone_inhibit      = pin.low_freq
                                     | radio_or_ptt
                                     | ~siren_on;
        next_ctl.airhorn_run       = air_req;
        next_ctl.rate_discharge_en = ~peak_req;
        next_ctl.tone_src_airhorn  = air_req;
        next_ctl.rate_square       = (mode == SMT_MODE_TWO_TONE);
        next_ctl.yelp_ctrl         = (mode == SMT_MODE_YELP)
                                     ^ toggle;
        next_ctl.audio_radio       = (mode == SMT_MODE_RADIO);
        next_ctl.bias_en           = radio_or_ptt;
        next_ctl.horn_pulse        = ring_pulse;
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctl_o    <= CTL_RESET;
            mode_o   <= SMT_MODE_NONE;
            toggle_o <= 1'b0;
        end else if (ce_i) begin
            ctl_o    <= next_ctl;
            mode_o   <= mode;
            toggle_o <= toggle;
        end
    end

endmodule : smt_siren_mode_tone_control
`default_nettype wire

// File: smt_panel_model.sv
// Front-panel switches and vehicle horn ring model
`default_nettype none
module smt_panel_model
    import smt_pkg::*;
(
    input  wire logic             sys_clk_i,
    input  wire smt_panel_s       base_i,
    input  wire logic [SEL_W-1:0] sel_i,
    input  wire logic             ring_i,
    input  wire logic             ring_low_i,
    output var  smt_panel_s       panel_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [SEL_W-1:0] pos = SEL_NONE;
    // Non-shorting selector rests on no stop between two stops
    always @(posedge sys_clk_i) begin
        pos <= (pos != sel_i && pos != SEL_NONE) ? SEL_NONE : sel_i;
    end
    // Horn ring closes to either the high side or the low side
    always_comb begin
        panel_o          = base_i;
        panel_o.selector = pos;
        panel_o.ring_pos = ring_i && !ring_low_i;
        panel_o.ring_neg = ring_i && ring_low_i;
    end
endmodule // smt_panel_model
`default_nettype wire

// File: smt_siren_chk.sv
// Port checker for the siren mode control
`default_nettype none
module smt_chk
    import smt_pkg::*;
#(
    parameter int unsigned HOLDOFF_CYCLES  = 20,
    parameter int unsigned DEBOUNCE_CYCLES = 4
) (
    input wire logic       sys_clk_i,
    input wire logic       rst_n_i,
    input wire logic       ce_i,
    input wire smt_panel_s panel_i,
    input wire smt_ctl_s   ctl_o,
    input wire smt_mode_e  mode_o,
    input wire logic       toggle_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    // ------------------------------------------------------------
    // Pins delayed to the output stage, run and power-good counts
    // ------------------------------------------------------------
    smt_panel_s  p1, p2, p3;
    logic [2:0]  run;
    logic [27:0] pg;
    logic [27:0] hp;
    smt_mode_e   m3;
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            p1  <= '0;
            p2  <= '0;
            p3  <= '0;
            run <= '0;
            pg  <= '0;
            hp  <= '0;
        end else if (ce_i) begin
            p1  <= panel_i;
            p2  <= p1;
            p3  <= p2;
            run <= (run == 3'h7) ? run : run + 3'h1;
            pg  <= !p3.power_good ? '0 : ((&pg) ? pg : pg + 28'h1);
            // Length of the current horn pulse, for the debounce check
            hp  <= !ctl_o.horn_pulse ? '0 : ((&hp) ? hp : hp + 28'h1);
        end else begin
            run <= '0;
        end
    end
    wire logic [4:0] s   = p3.selector;
    wire logic       rad = (s == 5'h01);
    wire logic       ok  = (run == 3'h7);
    wire logic       sm  = !p3.ptt && (s == 5'h02 || s == 5'h04 ||
                                        s == 5'h08 || s == 5'h10);
    wire logic       aj  = p3.jumper_a && p3.jumper_b;
    wire logic       air = sm && (p3.paddle_up || (s == 5'h02 ||
                           s == 5'h10) && aj && ctl_o.horn_pulse);
    // Expected decoded mode
    always_comb begin
        case (s)
            5'h02: m3 = SMT_MODE_MANUAL;
            5'h04: m3 = SMT_MODE_WAIL;
            5'h08: m3 = SMT_MODE_YELP;
            5'h10: m3 = SMT_MODE_TWO_TONE;
            default: m3 = SMT_MODE_NONE;
        endcase
        if (p3.ptt) m3 = SMT_MODE_PA;
        if (rad) m3 = SMT_MODE_RADIO;
    end
    property p_bias; ok |-> ctl_o.bias_en == (rad || p3.ptt); endproperty
    a_bias: assert property (p_bias)
        else $error("bias enable wrong");
    property p_inh; ok && (p3.low_freq || rad || p3.ptt)
        |-> ctl_o.tone_inhibit; endproperty
    a_inh: assert property (p_inh)
        else $error("tone inhibit missing");
    property p_mode; ok |-> mode_o == m3; endproperty
    a_mode: assert property (p_mode)
        else $error("mode decode wrong");
    property p_peak; ok |-> ctl_o.rate_discharge_en == !(sm &&
        (p3.paddle_down || s == 5'h02 && !aj && ctl_o.horn_pulse));
    endproperty
    a_peak: assert property (p_peak)
        else $error("peak control wrong");
    property p_air; ok |-> ctl_o.airhorn_run == air &&
        ctl_o.tone_src_airhorn == air; endproperty
    a_air: assert property (p_air)
        else $error("air horn control wrong");
    property p_clr; ok && s == 5'h00 |-> ##[0:2] !toggle_o; endproperty
    a_clr: assert property (p_clr)
        else $error("toggle not cleared");
    property p_pulse; ok && p3.power_good && pg >= HOLDOFF_CYCLES + 4
        |-> ctl_o.horn_pulse == (p3.ring_pos || p3.ring_neg); endproperty
    a_pulse: assert property (p_pulse)
        else $error("horn pulse wrong");
    property p_hold; ok && pg < HOLDOFF_CYCLES - 3 |-> !ctl_o.horn_pulse;
    endproperty
    a_hold: assert property (p_hold)
        else $error("horn pulse before hold-off");
    property p_yelp; ok && $stable(toggle_o) && $stable(s) && !p3.ptt &&
        !$past(p3.ptt) |-> ctl_o.yelp_ctrl == ((s == 5'h08) ^ toggle_o);
    endproperty
    a_yelp: assert property (p_yelp)
        else $error("yelp line wrong");
    // A toggle needs a full debounce span of pulse in wail or yelp
    property p_tap; ok && $rose(toggle_o) |-> hp >= DEBOUNCE_CYCLES &&
        ($past(mode_o) == SMT_MODE_WAIL || $past(mode_o) == SMT_MODE_YELP);
    endproperty
    a_tap: assert property (p_tap)
        else $error("toggle without debounced tap");
endmodule // smt_chk
bind smt_siren_mode_tone_control smt_chk #(
    .HOLDOFF_CYCLES(HOLDOFF_CYCLES), .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)
) CHK (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .panel_i(panel_i), .ctl_o(ctl_o), .mode_o(mode_o), .toggle_o(toggle_o));
`default_nettype wire

// File: tb_top.sv
// Self-checking bench for the siren mode control
`default_nettype none
module tb_top
    import smt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic             sys_clk = 1'b0;
    logic             rst_n   = 1'b0;
    logic             ce      = 1'b1;
    smt_panel_s       base    = 15'h0001; // Only power good set
    logic [SEL_W-1:0] sel     = SEL_NONE;
    logic             ring    = 1'b0;
    logic             ring_low = 1'b0;
    smt_panel_s       panel;
    smt_ctl_s         ctl;
    smt_mode_e        mode;
    logic             toggle;
    logic [7:0]       lf = 8'h1f;
    int               err_count = 0;
    int               checks_done = 0;
    logic [4:0] sels [8] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h08, 5'h10,
                             5'h03, 5'h18};
    always #4 sys_clk = ~sys_clk;
    smt_panel_model PM (.sys_clk_i(sys_clk), .base_i(base), .sel_i(sel),
        .ring_i(ring), .ring_low_i(ring_low), .panel_o(panel));
    smt_siren_mode_tone_control #(.HOLDOFF_CYCLES(20), .DEBOUNCE_CYCLES(4))
    DUT (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .ce_i(ce),
        .panel_i(panel), .ctl_o(ctl), .mode_o(mode), .toggle_o(toggle));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("errors %0d, checks %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic nw(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    // Press and release the horn ring, checking while it is held
    task automatic hold(input logic low, input logic ep, input logic [1:0] ex);
        @(posedge sys_clk);
        ring <= 1'b1;
        ring_low <= low;
        nw(10);
        chk(ctl.horn_pulse, ep);
        chk({ctl.rate_discharge_en, ctl.airhorn_run}, ex);
        @(posedge sys_clk);
        ring <= 1'b0;
        nw(10);
        chk(ctl.horn_pulse, 1'b0);
    endtask
    function automatic smt_mode_e exp_mode(input logic [4:0] s, input logic p);
        if (s == 5'h01) return SMT_MODE_RADIO;
        if (p) return SMT_MODE_PA;
        case (s)
            5'h02: return SMT_MODE_MANUAL;
            5'h04: return SMT_MODE_WAIL;
            5'h08: return SMT_MODE_YELP;
            5'h10: return SMT_MODE_TWO_TONE;
            default: return SMT_MODE_NONE;
        endcase
    endfunction
    function automatic logic [7:0] nxt(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    // Cuts a hung run short
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        stop_test();
    end
    // Main sequence
    initial begin
        smt_mode_e m;
        logic      sv;
        nw(5);
        chk(ctl, CTL_RESET);
        chk({mode, toggle}, 4'h0);
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        sel <= 5'h04;
        hold(1'b0, 1'b0, 2'b10);
        chk(toggle, 1'b0);
        nw(20);
        hold(1'b1, 1'b1, 2'b10);
        chk({toggle, ctl.yelp_ctrl}, 2'b11);
        hold(1'b0, 1'b1, 2'b10);
        chk({toggle, ctl.yelp_ctrl}, 2'b00);
        hold(1'b1, 1'b1, 2'b10);
        @(posedge sys_clk);
        sel <= 5'h08;
        nw(10);
        chk({toggle, ctl.yelp_ctrl}, 2'b01);
        hold(1'b0, 1'b1, 2'b10);
        chk({toggle, ctl.yelp_ctrl}, 2'b10);
        // Press-and-hold in manual, two-tone and wail with several jumper pairs
        for (int i = 0; i < 6; i++) begin
            @(posedge sys_clk);
            sel <= (i < 3) ? 5'h02 : ((i == 5) ? 5'h04 : 5'h10);
            base.jumper_a <= (i != 0 && i != 4);
            base.jumper_b <= (i == 1 || i > 2);
            nw(8);
            hold(1'b0, 1'b1, (i == 0 || i == 2) ? 2'b00 :
                 ((i == 4 || i == 5) ? 2'b10 : 2'b11));
        end
        chk(ctl.rate_square, 1'b0);
        @(posedge sys_clk);
        base.power_good <= 1'b0;
        hold(1'b0, 1'b0, 2'b10);
        @(posedge sys_clk);
        base.power_good <= 1'b1;
        // Random panel settings against the decode
        for (int i = 0; i < 150; i++) begin
            lf = nxt(nxt(lf));
            @(posedge sys_clk);
            sel <= sels[lf[2:0]];
            base.ptt <= lf[3];
            base.paddle_up <= lf[4];
            base.paddle_down <= lf[5];
            base.low_freq <= lf[6];
            nw(8);
            m = exp_mode(sels[lf[2:0]], lf[3]);
            sv = (m == SMT_MODE_MANUAL || m == SMT_MODE_WAIL ||
                  m == SMT_MODE_YELP || m == SMT_MODE_TWO_TONE);
            chk(mode, m);
            chk(ctl.bias_en, m == SMT_MODE_RADIO || lf[3]);
            chk(ctl.audio_radio, m == SMT_MODE_RADIO);
            chk(ctl.tone_inhibit, lf[6] || lf[3] || !sv);
            chk(ctl.rate_square, m == SMT_MODE_TWO_TONE);
            chk({ctl.rate_discharge_en, ctl.airhorn_run},
                {!(sv && lf[5]), sv && lf[4]});
        end
        // Clock enable low freezes the decode, then the pipeline resumes
        @(posedge sys_clk);
        ce <= 1'b0;
        sel <= (m == SMT_MODE_RADIO) ? 5'h02 : 5'h01;
        base.ptt <= 1'b0;
        nw(8);
        chk(mode, m);
        @(posedge sys_clk);
        ce <= 1'b1;
        nw(8);
        chk(mode, (m == SMT_MODE_RADIO) ? SMT_MODE_MANUAL
                                        : SMT_MODE_RADIO);
        stop_test();
    end
endmodule // tb_top
`default_nettype wire
